// ### design/ddi_regs.svh
`ifndef DDI_REGS_SVH
`define DDI_REGS_SVH

// register offsets, byte addresses on the control bus
`define DDI_OFF_CTRL      12'h000
`define DDI_OFF_STATUS    12'h004
`define DDI_OFF_MR        12'h008
`define DDI_OFF_EMR1      12'h00c
`define DDI_OFF_EMR2      12'h010
`define DDI_OFF_EMR3      12'h014

// field positions
`define DDI_CTRL_START    0
`define DDI_STAT_BUSY     0
`define DDI_STAT_DONE     1
`define DDI_STAT_STATE    4
`define DDI_RST_CFG       14'h0000

// bank select codes for the register-set command
`define DDI_BA_MR         2'h0
`define DDI_BA_EMR1       2'h1
`define DDI_BA_EMR2       2'h2
`define DDI_BA_EMR3       2'h3

// address pin positions
`define DDI_A_DLL_EN      0
`define DDI_A_TEST        7
`define DDI_A_OCD         7
`define DDI_A_DLL_RST     8
`define DDI_A_ALLBANK     10
`define DDI_A_HIGH        13
`define DDI_OCD_DEFAULT   3'h7
`define DDI_OCD_EXIT      3'h0

// timing
`define DDI_CLK_MHZ       250
`define DDI_T_STABLE_US   200
`define DDI_T_CKE_NS      400
`define DDI_DLL_LOCK_CK   200
`define DDI_MIN_REFRESH   2

`endif

// ### design/ddi_pkg.sv
package ddi_pkg;

  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_STABLE  = 4'h1,
    S_CKE     = 4'h2,
    S_PREA1   = 4'h3,
    S_EMR2    = 4'h4,
    S_EMR3    = 4'h5,
    S_EMR1    = 4'h6,
    S_MRDLL   = 4'h7,
    S_PREA2   = 4'h8,
    S_REF     = 4'h9,
    S_MRRUN   = 4'ha,
    S_OCDDEF  = 4'hb,
    S_OCDEXIT = 4'hc,
    S_DONE    = 4'hd
  } ddi_state_t;

  // {row strobe, column strobe, write enable}, all active low
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_NOP = 3'h7
  } ddi_cmd_t;

endpackage : ddi_pkg

// ### design/ddi_cfg_if.sv
`timescale 1ns/1ns
interface ddi_cfg_if;
  logic                 start;
  logic [13:0]          mr;
  logic [13:0]          emr1;
  logic [13:0]          emr2;
  logic [13:0]          emr3;
  logic                 busy;
  logic                 done;
  ddi_pkg::ddi_state_t  state;

  modport regs (output start, mr, emr1, emr2, emr3, input busy, done, state);
  modport core (input start, mr, emr1, emr2, emr3, output busy, done, state);
endinterface : ddi_cfg_if

// ### design/ddi_apb_regs.sv
`timescale 1ns/1ns
`include "ddi_regs.svh"
module ddi_apb_regs (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // towards the sequencer
  ddi_cfg_if.regs          cfg
);
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        start_q;
  logic [13:0] mr_q;
  logic [13:0] emr1_q;
  logic [13:0] emr2_q;
  logic [13:0] emr3_q;
  logic [31:0] rdata_d;
  logic        hit_d;
  logic        access;
  logic        acc_done;

  assign access   = i_psel & i_penable;
  assign acc_done = access & pready_q;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    unique case (i_paddr)
      `DDI_OFF_CTRL:   rdata_d = 32'h0000_0000;
      `DDI_OFF_STATUS:
      begin
        rdata_d[`DDI_STAT_BUSY]        = cfg.busy;
        rdata_d[`DDI_STAT_DONE]        = cfg.done;
        rdata_d[`DDI_STAT_STATE +: 4]  = cfg.state;
      end
      `DDI_OFF_MR:     rdata_d[13:0] = mr_q;
      `DDI_OFF_EMR1:   rdata_d[13:0] = emr1_q;
      `DDI_OFF_EMR2:   rdata_d[13:0] = emr2_q;
      `DDI_OFF_EMR3:   rdata_d[13:0] = emr3_q;
      default:         hit_d = 1'b0;
    endcase
  end

  // one wait state: answer lands on the second access cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= access & ~pready_q;
      prdata_q  <= (access & ~pready_q) ? rdata_d : 32'h0000_0000;
      pslverr_q <= access & ~pready_q & ~hit_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      start_q <= 1'b0;
      mr_q    <= `DDI_RST_CFG;
      emr1_q  <= `DDI_RST_CFG;
      emr2_q  <= `DDI_RST_CFG;
      emr3_q  <= `DDI_RST_CFG;
    end
    else
    begin
      start_q <= acc_done & i_pwrite & (i_paddr == `DDI_OFF_CTRL) & i_pwdata[`DDI_CTRL_START];
      if (acc_done & i_pwrite)
      begin
        unique case (i_paddr)
          `DDI_OFF_MR:   mr_q   <= i_pwdata[13:0];
          `DDI_OFF_EMR1: emr1_q <= i_pwdata[13:0];
          `DDI_OFF_EMR2: emr2_q <= i_pwdata[13:0];
          `DDI_OFF_EMR3: emr3_q <= i_pwdata[13:0];
          default:       ;
        endcase
      end
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign cfg.start = start_q;
  assign cfg.mr    = mr_q;
  assign cfg.emr1  = emr1_q;
  assign cfg.emr2  = emr2_q;
  assign cfg.emr3  = emr3_q;
endmodule : ddi_apb_regs

// ### design/ddi_init_ctrl.sv
`timescale 1ns/1ns
`include "ddi_regs.svh"
// Summary of operation
// (RULE_01) activate takes bank from BA and row from address pins, 14 or 13 bits
// (RULE_02) read/write address gives start column and auto-precharge choice
// (RULE_03) while powering up hold CKE low and ODT low
// (RULE_04) run the clock stable at least 200 us before continuing
// (RULE_05) NOPs while raising CKE, wait 400 ns, then precharge all
// (RULE_06) write extended register 2, then extended register 3
// (RULE_07) write extended register 1 with A0 low enabling DLL, A13 low
// (RULE_08) write mode register with A8 high to reset the DLL
// (RULE_09) then precharge all and at least two auto-refresh commands
// (RULE_10) rewrite mode register with A8 low
// (RULE_11) 200 clocks after DLL reset: OCD default then OCD exit
// (RULE_12) every register write supplies all fields of the register
// (RULE_13) writes to extended registers 2/3 are followed by MR and EMR1 writes
// (RULE_14) all register writes finish before any read or write
// (RULE_15) register-set only with all banks precharged, CKE high a cycle before
// (RULE_16) register-set is CS, RAS, CAS, WE low; BA selects the register
// (RULE_17) wait the register-set cycle time before the next command
// (RULE_18) register writes keep array contents, so reinit is allowed anytime
// (RULE_19) mode register has no reset value; it must be written after power-up
// (RULE_20) mode fields: burst length, burst type, latency, DLL reset, recovery
// (RULE_21) test-mode bit A7 low and A13 low on mode register writes
// (RULE_22) A12 picks standard or low-power power-down
// (RULE_23) burst length codes: 010 four, 011 eight
// (RULE_24) read latency codes: 011, 100, 101 for three to five
// (RULE_25) write recovery codes 001..101, at least tWR over tCK rounded up
// (RULE_26) a device model flags reads or writes before initialisation completes
module ddi_init_ctrl #(
  parameter int unsigned CK_HALF     = 4,
  parameter int unsigned STABLE_CYC  = `DDI_T_STABLE_US * `DDI_CLK_MHZ,
  parameter int unsigned RP_CK       = 4,
  parameter int unsigned RFC_CK      = 32,
  parameter int unsigned MRD_CK      = 2,
  parameter int unsigned NUM_REFRESH = `DDI_MIN_REFRESH,
  parameter int unsigned WAIT_W      = 20
) (
  // clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // memory pins
  output logic             O_CK,
  output logic             O_CK_N,
  output logic             O_CKE,
  output logic             O_ODT,
  output logic             O_CS_N,
  output logic             O_RAS_N,
  output logic             O_CAS_N,
  output logic             O_WE_N,
  output logic      [1:0]  O_BA,
  output logic      [13:0] O_A,
  // status
  output logic             O_INIT_DONE
);
  localparam int unsigned PER          = 2 * CK_HALF;
  localparam int unsigned STABLE_SLOTS = (STABLE_CYC + PER - 1) / PER;
  localparam int unsigned CKE_CYC      = (`DDI_T_CKE_NS * `DDI_CLK_MHZ + 999) / 1000;
  localparam int unsigned CKE_SLOTS    = (CKE_CYC + PER - 1) / PER;
  localparam int unsigned DLL_LOCK     = `DDI_DLL_LOCK_CK;

  ddi_cfg_if cfg ();

  ddi_apb_regs u_regs (
    .i_clk     (I_CLOCK),
    .i_rst     (I_RST),
    .i_psel    (I_PSEL),
    .i_penable (I_PENABLE),
    .i_pwrite  (I_PWRITE),
    .i_paddr   (I_PADDR),
    .i_pwdata  (I_PWDATA),
    .o_prdata  (O_PRDATA),
    .o_pready  (O_PREADY),
    .o_pslverr (O_PSLVERR),
    .cfg       (cfg.regs)
  );

  ddi_pkg::ddi_state_t state_q;
  ddi_pkg::ddi_state_t next_d;
  ddi_pkg::ddi_cmd_t   cmd_d;
  logic [WAIT_W-1:0]   wait_q;
  logic [WAIT_W-1:0]   gap_d;
  logic [7:0]          div_q;
  logic [7:0]          ref_q;
  logic [7:0]          dll_cnt_q;
  logic                run_q;
  logic                ck_q;
  logic                ck_n_q;
  logic                cke_q;
  logic                odt_q;
  logic                done_q;
  logic                cs_n_q;
  logic [2:0]          cmd_q;
  logic [1:0]          ba_q;
  logic [13:0]         a_q;
  logic [1:0]          ba_d;
  logic [13:0]         a_d;
  logic                slot;
  logic                cmd_state;
  logic                issue;

  // clock divider; commands change on the falling edge of CK so they sit
  // centred under the rising edge the memory samples on
  assign slot = run_q && (div_q == 8'(CK_HALF - 1));

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      div_q  <= 8'h00;
      ck_q   <= 1'b0;
      ck_n_q <= 1'b1;
    end
    else if (!run_q)
    begin
      div_q  <= 8'h00;
      ck_q   <= 1'b0;
      ck_n_q <= 1'b1;
    end
    else
    begin
      div_q  <= (div_q == 8'(PER - 1)) ? 8'h00 : div_q + 8'h01;
      ck_q   <= (div_q == 8'(PER - 1)) || (div_q < 8'(CK_HALF - 1));
      ck_n_q <= !((div_q == 8'(PER - 1)) || (div_q < 8'(CK_HALF - 1)));
    end
  end

  assign cmd_state = (state_q >= ddi_pkg::S_PREA1) && (state_q <= ddi_pkg::S_OCDEXIT);
  assign issue     = slot && (wait_q == '0) && cmd_state &&
                     ((state_q != ddi_pkg::S_OCDDEF) || (dll_cnt_q >= 8'(DLL_LOCK))); // RULE_11

  // command, bank and address for the current step; every field not forced by a rule
  // comes from the software copy so a partial change never leaves stale bits behind
  always_comb
  begin
    cmd_d  = ddi_pkg::CMD_NOP;
    ba_d   = 2'h0;
    a_d    = 14'h0000;
    gap_d  = WAIT_W'(MRD_CK - 1); // RULE_17
    next_d = state_q;
    unique case (state_q)
      ddi_pkg::S_PREA1, ddi_pkg::S_PREA2:
      begin
        cmd_d              = ddi_pkg::CMD_PRE; // RULE_05 RULE_09
        a_d[`DDI_A_ALLBANK] = 1'b1;
        gap_d              = WAIT_W'(RP_CK - 1);
        next_d             = (state_q == ddi_pkg::S_PREA1) ? ddi_pkg::S_EMR2 : ddi_pkg::S_REF;
      end
      ddi_pkg::S_EMR2:
      begin
        cmd_d  = ddi_pkg::CMD_MRS; // RULE_06
        ba_d   = `DDI_BA_EMR2;
        a_d    = cfg.emr2; // RULE_12
        next_d = ddi_pkg::S_EMR3;
      end
      ddi_pkg::S_EMR3:
      begin
        cmd_d  = ddi_pkg::CMD_MRS; // RULE_06
        ba_d   = `DDI_BA_EMR3;
        a_d    = cfg.emr3;
        next_d = ddi_pkg::S_EMR1; // RULE_13
      end
      ddi_pkg::S_EMR1, ddi_pkg::S_OCDDEF, ddi_pkg::S_OCDEXIT:
      begin
        cmd_d                  = ddi_pkg::CMD_MRS;
        ba_d                   = `DDI_BA_EMR1;
        a_d                    = cfg.emr1; // RULE_12
        a_d[`DDI_A_DLL_EN]     = 1'b0; // RULE_07
        a_d[`DDI_A_HIGH]       = 1'b0; // RULE_07
        a_d[`DDI_A_OCD +: 3]   = (state_q == ddi_pkg::S_OCDDEF) ? `DDI_OCD_DEFAULT
                                                                : `DDI_OCD_EXIT; // RULE_11
        next_d = (state_q == ddi_pkg::S_EMR1)   ? ddi_pkg::S_MRDLL :
                 (state_q == ddi_pkg::S_OCDDEF) ? ddi_pkg::S_OCDEXIT : ddi_pkg::S_DONE;
      end
      ddi_pkg::S_MRDLL, ddi_pkg::S_MRRUN:
      begin
        cmd_d                = ddi_pkg::CMD_MRS; // RULE_19
        ba_d                 = `DDI_BA_MR; // RULE_16
        a_d                  = cfg.mr; // RULE_12
        a_d[`DDI_A_TEST]     = 1'b0; // RULE_21
        a_d[`DDI_A_HIGH]     = 1'b0; // RULE_21
        a_d[`DDI_A_DLL_RST]  = (state_q == ddi_pkg::S_MRDLL); // RULE_08 RULE_10
        next_d = (state_q == ddi_pkg::S_MRDLL) ? ddi_pkg::S_PREA2 : ddi_pkg::S_OCDDEF;
      end
      ddi_pkg::S_REF:
      begin
        cmd_d  = ddi_pkg::CMD_REF; // RULE_09
        gap_d  = WAIT_W'(RFC_CK - 1);
        next_d = (ref_q + 8'h01 >= 8'(NUM_REFRESH)) ? ddi_pkg::S_MRRUN : ddi_pkg::S_REF;
      end
      default: ;
    endcase
  end

  // sequencer
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      state_q <= ddi_pkg::S_IDLE;
      wait_q  <= '0;
      run_q   <= 1'b0;
      cke_q   <= 1'b0; // RULE_03
      done_q  <= 1'b0;
      ref_q   <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        ddi_pkg::S_IDLE:
          if (cfg.start)
          begin
            run_q   <= 1'b1; // RULE_04
            // first slot lands only half a CK after the clock starts, so
            // count one whole slot more to keep the full stable time
            wait_q  <= WAIT_W'(STABLE_SLOTS);
            state_q <= ddi_pkg::S_STABLE;
          end
        ddi_pkg::S_STABLE, ddi_pkg::S_CKE:
          if (slot)
          begin
            if (wait_q != '0)
              wait_q <= wait_q - WAIT_W'(1); // RULE_04
            else if (state_q == ddi_pkg::S_STABLE)
            begin
              cke_q   <= 1'b1; // RULE_05
              wait_q  <= WAIT_W'(CKE_SLOTS - 1);
              state_q <= ddi_pkg::S_CKE;
            end
            else
              state_q <= ddi_pkg::S_PREA1; // RULE_15
          end
        ddi_pkg::S_DONE:
          if (cfg.start)
          begin
            // clock and CKE stay up, so reinit restarts at precharge-all
            done_q  <= 1'b0; // RULE_18
            ref_q   <= 8'h00;
            state_q <= ddi_pkg::S_PREA1;
          end
        ddi_pkg::S_PREA1, ddi_pkg::S_EMR2, ddi_pkg::S_EMR3, ddi_pkg::S_EMR1,
        ddi_pkg::S_MRDLL, ddi_pkg::S_PREA2, ddi_pkg::S_REF, ddi_pkg::S_MRRUN,
        ddi_pkg::S_OCDDEF, ddi_pkg::S_OCDEXIT:
          if (slot && (wait_q != '0))
            wait_q <= wait_q - WAIT_W'(1); // RULE_17
          else if (issue)
          begin
            wait_q  <= gap_d;
            state_q <= next_d;
            if (state_q == ddi_pkg::S_REF)
              ref_q <= ref_q + 8'h01;
            if (state_q == ddi_pkg::S_OCDEXIT)
              done_q <= 1'b1; // RULE_14
          end
        default: state_q <= ddi_pkg::S_IDLE;
      endcase
    end
  end

  // clocks elapsed since the DLL reset write, saturating
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      dll_cnt_q <= 8'h00;
    else if (issue && (state_q == ddi_pkg::S_MRDLL))
      dll_cnt_q <= 8'h00;
    else if (slot && (dll_cnt_q < 8'(DLL_LOCK)))
      dll_cnt_q <= dll_cnt_q + 8'h01; // RULE_11
  end

  // command pins: NOP in every slot that carries no command
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      cs_n_q <= 1'b1;
      cmd_q  <= ddi_pkg::CMD_NOP;
      ba_q   <= 2'h0;
      a_q    <= 14'h0000;
      odt_q  <= 1'b0; // RULE_03
    end
    else
    begin
      odt_q <= 1'b0; // RULE_03
      if (slot)
      begin
        cs_n_q <= !issue; // RULE_16
        cmd_q  <= issue ? cmd_d : ddi_pkg::CMD_NOP; // RULE_05
        ba_q   <= issue ? ba_d : 2'h0;
        a_q    <= issue ? a_d : 14'h0000; // RULE_01
      end
    end
  end

  assign cfg.busy  = (state_q != ddi_pkg::S_IDLE) && (state_q != ddi_pkg::S_DONE);
  assign cfg.done  = done_q;
  assign cfg.state = state_q;

  assign O_CK        = ck_q;
  assign O_CK_N      = ck_n_q;
  assign O_CKE       = cke_q;
  assign O_ODT       = odt_q;
  assign O_CS_N      = cs_n_q;
  assign O_RAS_N     = cmd_q[2];
  assign O_CAS_N     = cmd_q[1];
  assign O_WE_N      = cmd_q[0];
  assign O_BA        = ba_q;
  assign O_A         = a_q;
  assign O_INIT_DONE = done_q;

  // helper counters for the timing checks
  logic [31:0] run_cyc_q;
  logic [15:0] cke_cyc_q;

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      run_cyc_q <= 32'h0000_0000;
      cke_cyc_q <= 16'h0000;
    end
    else
    begin
      if (run_q && !cke_q)
        run_cyc_q <= run_cyc_q + 32'h0000_0001;
      if (cke_q && (cke_cyc_q != 16'hffff))
        cke_cyc_q <= cke_cyc_q + 16'h0001;
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  a_idle_pins_low: assert property ( // RULE_03
    (state_q == ddi_pkg::S_IDLE) |-> (!O_CKE && !O_ODT && !O_CK))
    else $error("cke, odt or ck active before start");
  a_clock_stable: assert property ( // RULE_04
    $rose(O_CKE) |-> (run_cyc_q >= 32'(STABLE_CYC)))
    else $error("cke raised before clock stable time");
  a_cke_to_prea: assert property ( // RULE_05
    (issue && (state_q == ddi_pkg::S_PREA1)) |-> (cke_cyc_q >= 16'(CKE_CYC)))
    else $error("precharge-all too soon after cke rise");
  a_prea_all: assert property ( // RULE_05
    (issue && (cmd_d == ddi_pkg::CMD_PRE)) |=>
      (!O_CS_N && (cmd_q == ddi_pkg::CMD_PRE) && O_A[`DDI_A_ALLBANK]))
    else $error("precharge not issued as precharge-all");
  a_emr2_then_emr3: assert property ( // RULE_06
    (issue && (state_q == ddi_pkg::S_EMR2)) |=> (O_BA == `DDI_BA_EMR2)
      ##1 (state_q == ddi_pkg::S_EMR3))
    else $error("extended register 2 write malformed");
  a_emr1_dll_en: assert property ( // RULE_07
    (issue && (state_q == ddi_pkg::S_EMR1)) |=>
      ((O_BA == `DDI_BA_EMR1) && !O_A[`DDI_A_DLL_EN] && !O_A[`DDI_A_HIGH]))
    else $error("dll enable write malformed");
  a_mr_dll_reset: assert property ( // RULE_08 RULE_21
    (issue && (state_q == ddi_pkg::S_MRDLL)) |=> ((O_BA == `DDI_BA_MR) &&
      O_A[`DDI_A_DLL_RST] && !O_A[`DDI_A_TEST] && !O_A[`DDI_A_HIGH]))
    else $error("dll reset write malformed");
  a_mr_run_refresh: assert property ( // RULE_09 RULE_10
    (issue && (state_q == ddi_pkg::S_MRRUN)) |->
      (ref_q >= 8'(NUM_REFRESH)) ##1 !O_A[`DDI_A_DLL_RST])
    else $error("final mode write without refreshes or with dll reset");
  a_ocd_after_lock: assert property ( // RULE_11
    (issue && (state_q == ddi_pkg::S_OCDDEF)) |-> (dll_cnt_q >= 8'(DLL_LOCK)))
    else $error("ocd default issued before dll lock time");
  a_mrs_cke_high: assert property ( // RULE_15
    (!O_CS_N && (cmd_q == ddi_pkg::CMD_MRS)) |-> (O_CKE && $past(O_CKE, 2)))
    else $error("register-set without cke high");
  a_cmd_hold: assert property ( // RULE_17
    !slot |=> $stable({O_CS_N, O_RAS_N, O_CAS_N, O_WE_N, O_BA, O_A}))
    else $error("command pins changed mid clock");
  a_done_last: assert property ( // RULE_14
    $rose(O_INIT_DONE) |-> ($past(state_q) == ddi_pkg::S_OCDEXIT))
    else $error("done raised out of sequence");

  c_init_done: cover property ($rose(O_INIT_DONE));
  c_second_refresh: cover property (issue && (state_q == ddi_pkg::S_REF) && (ref_q == 8'h01));
  c_reinit: cover property ((state_q == ddi_pkg::S_DONE) && cfg.start);
endmodule : ddi_init_ctrl

// ### dv/ddi_dev_model.sv
`timescale 1ns/1ns
module ddi_dev_model #(
  parameter int MRD = 2
) (
  // memory pins from the controller
  input wire logic        i_ck,
  input wire logic        i_cke,
  input wire logic        i_odt,
  input wire logic        i_cs_n,
  input wire logic        i_ras_n,
  input wire logic        i_cas_n,
  input wire logic        i_we_n,
  input wire logic [1:0]  i_ba,
  input wire logic [13:0] i_a
);
  logic [18:0] log_q[$];
  int          ckn_q[$];
  // left unknown until written
  logic [13:0] mode_q;
  logic [13:0] ext_q [1:3];
  logic [13:0] row_q;
  logic [2:0]  cmd;
  int          ckn = 0;
  int          ckn_cke = 0;
  int          last_mrs = -99;
  int          viol = 0;
  bit          cke_d = 0;
  bit          open_any = 0;
  bit          ocd_def = 0;
  bit          ready = 0;

  // behavioural: samples on the memory clock itself, no array is held
  always @(posedge i_ck)
  begin
    ckn++;
    cmd = {i_ras_n, i_cas_n, i_we_n};
    if (i_cke && !cke_d && ckn_cke == 0)
      ckn_cke = ckn;
    if (i_odt !== 1'b0)
      viol++;
    if (i_cs_n === 1'b0 && cmd !== ddi_pkg::CMD_NOP)
    begin
      if (!cke_d || ckn - last_mrs < MRD)
        viol++;
      log_q.push_back({cmd, i_ba, i_a});
      ckn_q.push_back(ckn);
      case (cmd)
        ddi_pkg::CMD_MRS:
        begin
          last_mrs = ckn;
          if (open_any)
            viol++;
          if (i_ba == 2'h0)
          begin
            mode_q = i_a;
            if (!i_a[8] && (!(i_a[2:0] inside {3'h2, 3'h3})
                || !(i_a[6:4] inside {3'h3, 3'h4, 3'h5})
                || !(i_a[11:9] inside {[3'h1:3'h5]})))
              viol++;
            if (i_a[7] || i_a[13])
              viol++;
          end
          else
          begin
            ext_q[i_ba] = i_a;
            if (i_ba == 2'h1 && ocd_def && i_a[9:7] == 3'h0)
              ready = 1;
            if (i_ba == 2'h1)
              ocd_def = (i_a[9:7] == 3'h7);
          end
        end
        3'h3:
        begin
          open_any = 1;
          row_q = i_a;
        end
        ddi_pkg::CMD_PRE:
          if (i_a[10])
            open_any = 0;
        3'h4, 3'h5:
          if (!ready || !open_any)
            viol++;
        default:
          ;
      endcase
    end
    cke_d = i_cke;
  end
endmodule : ddi_dev_model

// ### dv/ddi_init_ctrl_test.sv
`timescale 1ns/1ns
`include "ddi_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module ddi_init_ctrl_test;
  localparam int STABLE = 64;
  localparam int NCMD = 11;
  // pre 2, register-set 0, refresh 1
  localparam logic [2:0]  e_cmd [NCMD] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h1,
                                           3'h0, 3'h0, 3'h0};
  localparam logic [15:0] e_baa [NCMD] = '{16'h0000, 16'h8005, 16'hc003, 16'h400c, 16'h1743,
                                           16'h0000, 16'h0000, 16'h0000, 16'h1643, 16'h438c,
                                           16'h400c};
  logic        clk = 0;
  logic        rst = 1;
  logic        psel = 0;
  logic        pen = 0;
  logic        pwr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, er, ck, ck_n, cke, odt, cs_n, ras_n, cas_n, we_n, done;
  logic [1:0]  ba;
  logic [13:0] a;
  int          checks = 0;
  int          mismatches = 0;
  int          cyc = 0;

  ddi_init_ctrl #(.STABLE_CYC(STABLE)) i_ddi_init_ctrl (
    .I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_CK(ck), .O_CK_N(ck_n), .O_CKE(cke), .O_ODT(odt), .O_CS_N(cs_n),
    .O_RAS_N(ras_n), .O_CAS_N(cas_n), .O_WE_N(we_n), .O_BA(ba), .O_A(a), .O_INIT_DONE(done));

  ddi_dev_model i_ddi_dev_model (
    .i_ck(ck), .i_cke(cke), .i_odt(odt), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
    .i_we_n(we_n), .i_ba(ba), .i_a(a));

  initial
    forever #2 clk = ~clk;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      $display("[ERR] cycle limit exp 0 got %0d", cyc);
      wrap_up();
    end
  end

  // entered just after a rising edge; one idle cycle after each transfer
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [11:0] ad, input logic [31:0] e, input string nm);
    apb(1'b0, ad, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask : rchk

  task automatic check_run(input int b);
    logic [18:0] e;
    for (int k = 0; k < NCMD; k++)
    begin
      e = i_ddi_dev_model.log_q[b + k];
      `CHK("command", e_cmd[k], e[18:16])
      if (e_cmd[k] == 3'h0)
        `CHK("register set", e_baa[k], e[15:0])
      else if (e_cmd[k] == 3'h2)
        `CHK("precharge all", 1'b1, e[10])
    end
    `CHK("dll settle", 1'b1,
      i_ddi_dev_model.ckn_q[b + 9] - i_ddi_dev_model.ckn_q[b + 4] >= 200)
  endtask : check_run

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("reset pins", 6'b001001, {cke, odt, cs_n, done, ck, ck_n})
    rchk(`DDI_OFF_MR, 32'h0000_0000, "mode reset");
    rchk(`DDI_OFF_STATUS, 32'h0000_0000, "status idle");
    rchk(12'h100, 32'h0000_0000, "unmapped read");
    `CHK("unmapped err", 1'b1, er)
    apb(1'b1, `DDI_OFF_MR, 32'h8000_36c3);
    apb(1'b1, `DDI_OFF_EMR1, 32'h0000_210d);
    apb(1'b1, `DDI_OFF_EMR2, 32'h0000_0005);
    apb(1'b1, `DDI_OFF_EMR3, 32'h0000_0003);
    apb(1'b1, `DDI_OFF_STATUS, 32'hffff_ffff);
    rchk(`DDI_OFF_MR, 32'h0000_36c3, "mode readback");
    rchk(`DDI_OFF_STATUS, 32'h0000_0000, "status kept");
    $display("test registers done");
    for (int r = 0; r < 2; r++)
    begin
      apb(1'b1, `DDI_OFF_CTRL, 32'h0000_0001);
      // a start while busy must not queue a second sequence
      apb(1'b1, `DDI_OFF_CTRL, 32'h0000_0001);
      apb(1'b0, `DDI_OFF_STATUS, 32'h0000_0000);
      `CHK("busy", 1'b1, rd[`DDI_STAT_BUSY])
      `CHK("done low", 1'b0, done)
      while (done !== 1'b1)
        @(posedge clk);
      rchk(`DDI_OFF_STATUS, 32'h0000_00d2, "status done");
      `CHK("ck pair", 1'b1, ck ^ ck_n)
      check_run(r * NCMD);
      $display("test init run %0d done", r);
    end
    `CHK("command count", 2 * NCMD, i_ddi_dev_model.log_q.size())
    `CHK("model flags", 0, i_ddi_dev_model.viol)
    `CHK("stable ck", 1'b1, (i_ddi_dev_model.ckn_cke - 1) * 8 >= STABLE)
    `CHK("cke to pre", 1'b1,
      (i_ddi_dev_model.ckn_q[0] - i_ddi_dev_model.ckn_cke) * 32 >= 400)
    $display("test sequence checks done");
    wrap_up();
  end
endmodule : ddi_init_ctrl_test
